// ### design/frcct_pkg.sv
// Package of constants for the free-running capture/compare timer
package frcct_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CAPSEL  = 8'h04;
    localparam logic [7:0] ADDR_EVCTL   = 8'h08;
    localparam logic [7:0] ADDR_OPTION  = 8'h0C;
    localparam logic [7:0] ADDR_CC0     = 8'h10;
    localparam logic [7:0] ADDR_CC1     = 8'h14;
    localparam logic [7:0] ADDR_COUNT   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN_BIT   = 0;
    localparam int OPT_OVF_BIT    = 0;
    localparam int OPT_CS0_BIT    = 4;
    localparam int OPT_CS1_BIT    = 5;
    localparam int IRQ_CH0_BIT    = 0;
    localparam int IRQ_CH1_BIT    = 1;
    localparam int IRQ_OVF_BIT    = 2;
    localparam int IRQ_WIDTH      = 3;

    // ------------------------------------------------------------
    // Write masks, reset values and counter constants
    // ------------------------------------------------------------
    localparam logic [7:0]  CAPSEL_MASK  = 8'h0F;
    localparam logic [7:0]  EVCTL_MASK   = 8'h0C;
    localparam logic [7:0]  OPTION_MASK  = 8'h30;
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE    = 16'h0001;

    // Capture edge codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ### design/frcct_edge_detect.sv
// Synchroniser and selectable edge detector for one capture input
`timescale 1ns/100ps
module frcct_edge_detect
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    output logic            edge_hit
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic hit_d;
    logic hit_q;

    // ------------------------------------------------------------
    // Edge selection
    // ------------------------------------------------------------
    always_comb
    begin
        hit_d = 1'b0;
        case (edge_sel)
            frcct_pkg::EDGE_RISE: hit_d = sync2_q & ~prev_q;
            frcct_pkg::EDGE_FALL: hit_d = ~sync2_q & prev_q;
            frcct_pkg::EDGE_BOTH: hit_d = sync2_q ^ prev_q;
            default:              hit_d = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            hit_q   <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            hit_q   <= hit_d;
        end
    end

    assign edge_hit = hit_q;
endmodule

// ### design/frcct_timer.sv
// Free-running 16-bit capture/compare timer with a Wishbone slave
`timescale 1ns/100ps
module frcct_timer
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        capture_in_zero,
    input  wire logic        capture_in_one,
    output logic             timer_out_zero,
    output logic             timer_out_one,
    output logic             chan_match_irq_zero,
    output logic             chan_match_irq_one,
    output logic             overflow_irq,
    output logic             irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int IRQ_W = frcct_pkg::IRQ_WIDTH;

    logic        run_q,    run_d;
    logic [7:0]  capsel_q, capsel_d;
    logic [7:0]  evctl_q,  evctl_d;
    logic [1:0]  csel_q,   csel_d;
    logic        ovf_q,    ovf_d;
    logic [15:0] cc_q [2];
    logic [15:0] cc_d [2];
    logic [15:0] cnt_q,    cnt_d;
    logic [1:0]  tout_q,   tout_d;
    logic [IRQ_W-1:0] st_q, st_d;
    logic [IRQ_W-1:0] msk_q, msk_d;
    logic [1:0]  chirq_q,  chirq_d;
    logic        ovirq_q,  ovirq_d;
    logic        irq_q,    irq_d;
    logic        ack_q,    ack_d;
    logic [31:0] rdat_q,   rdat_d;

    logic [1:0]  cap_hit;
    logic        req;
    logic        wr;
    logic [1:0]  ch_ev;
    logic        ov_ev;

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Capture inputs
    // ------------------------------------------------------------
    frcct_edge_detect u_edge0
    (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .pin_in   (capture_in_zero),
        .edge_sel (capsel_q[1:0]),
        .edge_hit (cap_hit[0])
    );

    frcct_edge_detect u_edge1
    (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .pin_in   (capture_in_one),
        .edge_sel (capsel_q[3:2]),
        .edge_hit (cap_hit[1])
    );

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [31:0] m;
        logic [31:0] mc;
        logic        start;
        m        = 32'h0000_0000;
        mc       = 32'h0000_0000;
        start    = 1'b0;
        run_d    = run_q;
        capsel_d = capsel_q;
        evctl_d  = evctl_q;
        csel_d   = csel_q;
        ovf_d    = ovf_q;
        cc_d     = cc_q;
        cnt_d    = cnt_q;
        tout_d   = tout_q;
        msk_d    = msk_q;
        ch_ev    = 2'b00;
        ov_ev    = 1'b0;
        ack_d    = req;
        rdat_d   = 32'h0000_0000;

        // Register writes
        if (wr)
        begin
            m = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
            if (wb_adr_i == frcct_pkg::ADDR_CTRL && wb_sel_i[0])
            begin
                run_d = m[frcct_pkg::CTRL_RUN_BIT];
                start = m[frcct_pkg::CTRL_RUN_BIT] & ~run_q;
            end
            else if (wb_adr_i == frcct_pkg::ADDR_CAPSEL && wb_sel_i[0])
                capsel_d = m[7:0] & frcct_pkg::CAPSEL_MASK;
            else if (wb_adr_i == frcct_pkg::ADDR_EVCTL && wb_sel_i[0])
                evctl_d = m[7:0] & frcct_pkg::EVCTL_MASK;
            else if (wb_adr_i == frcct_pkg::ADDR_OPTION && wb_sel_i[0])
            begin
                csel_d = {m[frcct_pkg::OPT_CS1_BIT], m[frcct_pkg::OPT_CS0_BIT]};
                if (!m[frcct_pkg::OPT_OVF_BIT])
                    ovf_d = 1'b0;
            end
            else if (wb_adr_i == frcct_pkg::ADDR_CC0)
            begin
                mc      = lane_merge({16'h0000, cc_q[0]}, wb_dat_i, wb_sel_i);
                cc_d[0] = mc[15:0];
            end
            else if (wb_adr_i == frcct_pkg::ADDR_CC1)
            begin
                mc      = lane_merge({16'h0000, cc_q[1]}, wb_dat_i, wb_sel_i);
                cc_d[1] = mc[15:0];
            end
            else if (wb_adr_i == frcct_pkg::ADDR_IRQ_MSK && wb_sel_i[0])
                msk_d = m[IRQ_W-1:0];
        end

        // Counter
        if (start)
        begin
            cnt_d  = frcct_pkg::RESET_WORD;
            tout_d = ~tout_q;
        end
        else if (run_q)
        begin
            cnt_d = cnt_q + frcct_pkg::COUNT_ONE;
            if (cnt_q == frcct_pkg::COUNT_MAX)
            begin
                ov_ev = 1'b1;
                ovf_d = 1'b1;
            end
            for (int c = 0; c < 2; c++)
            begin
                if (!csel_q[c] && cc_q[c] == cnt_q)
                begin
                    ch_ev[c]  = 1'b1;
                    tout_d[c] = ~tout_q[c];
                end
            end
        end

        // Capture overrides a same-cycle write to the channel
        for (int c = 0; c < 2; c++)
        begin
            if (run_q && csel_q[c] && cap_hit[c])
            begin
                cc_d[c]  = cnt_q;
                ch_ev[c] = 1'b1;
            end
        end

        // Register reads
        if (req && !wb_we_i)
        begin
            if (wb_adr_i == frcct_pkg::ADDR_CTRL)
                rdat_d = {31'h0000_0000, run_q};
            else if (wb_adr_i == frcct_pkg::ADDR_CAPSEL)
                rdat_d = {24'h00_0000, capsel_q};
            else if (wb_adr_i == frcct_pkg::ADDR_EVCTL)
                rdat_d = {24'h00_0000, evctl_q};
            else if (wb_adr_i == frcct_pkg::ADDR_OPTION)
                rdat_d = {26'h000_0000, csel_q, 3'h0, ovf_q};
            else if (wb_adr_i == frcct_pkg::ADDR_CC0)
                rdat_d = {16'h0000, cc_q[0]};
            else if (wb_adr_i == frcct_pkg::ADDR_CC1)
                rdat_d = {16'h0000, cc_q[1]};
            else if (wb_adr_i == frcct_pkg::ADDR_COUNT)
                rdat_d = {16'h0000, cnt_q};
            else if (wb_adr_i == frcct_pkg::ADDR_IRQ_ST)
                rdat_d = {29'h0000_0000, st_q};
            else if (wb_adr_i == frcct_pkg::ADDR_IRQ_MSK)
                rdat_d = {29'h0000_0000, msk_q};
            else
                rdat_d = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status: set wins over write-one-to-clear
    // ------------------------------------------------------------
    always_comb
    begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        ev  = {ov_ev, ch_ev};
        clr = '0;
        if (wr && wb_adr_i == frcct_pkg::ADDR_IRQ_ST && wb_sel_i[0])
            clr = wb_dat_i[IRQ_W-1:0];
        st_d    = (st_q & ~clr) | ev;
        chirq_d = ch_ev;
        ovirq_d = ov_ev;
        irq_d   = |(st_d & msk_d);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_q    <= 1'b0;
            capsel_q <= frcct_pkg::RESET_BYTE;
            evctl_q  <= frcct_pkg::RESET_BYTE;
            csel_q   <= 2'b00;
            ovf_q    <= 1'b0;
            cc_q[0]  <= frcct_pkg::RESET_WORD;
            cc_q[1]  <= frcct_pkg::RESET_WORD;
            cnt_q    <= frcct_pkg::RESET_WORD;
            tout_q   <= 2'b00;
            st_q     <= '0;
            msk_q    <= '0;
            chirq_q  <= 2'b00;
            ovirq_q  <= 1'b0;
            irq_q    <= 1'b0;
            ack_q    <= 1'b0;
            rdat_q   <= 32'h0000_0000;
        end
        else
        begin
            run_q    <= run_d;
            capsel_q <= capsel_d;
            evctl_q  <= evctl_d;
            csel_q   <= csel_d;
            ovf_q    <= ovf_d;
            cc_q[0]  <= cc_d[0];
            cc_q[1]  <= cc_d[1];
            cnt_q    <= cnt_d;
            tout_q   <= tout_d;
            st_q     <= st_d;
            msk_q    <= msk_d;
            chirq_q  <= chirq_d;
            ovirq_q  <= ovirq_d;
            irq_q    <= irq_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
        end
    end

    assign wb_dat_o            = rdat_q;
    assign wb_ack_o            = ack_q;
    assign timer_out_zero      = tout_q[0];
    assign timer_out_one       = tout_q[1];
    assign chan_match_irq_zero = chirq_q[0];
    assign chan_match_irq_one  = chirq_q[1];
    assign overflow_irq        = ovirq_q;
    assign irq                 = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic start_w;
    assign start_w = wr && wb_adr_i == frcct_pkg::ADDR_CTRL && wb_sel_i[0]
                     && wb_dat_i[0] && !run_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_START_ZERO: assert property (
        (wr && wb_adr_i == frcct_pkg::ADDR_CTRL && wb_sel_i[0] && wb_dat_i[0] && !run_q)
        |=> (cnt_q == 16'h0000) && (tout_q == ~$past(tout_q)))
        else $error("counter did not start at zero with toggled outputs");
    AST_WRAP: assert property (
        (run_q && cnt_q == 16'hFFFF && !start_w) |=> (cnt_q == 16'h0000) && ovf_q && overflow_irq)
        else $error("overflow wrap misbehaved");
    AST_MATCH: assert property (
        (run_q && !start_w && !csel_q[0] && cc_q[0] == cnt_q)
        |=> chan_match_irq_zero && (timer_out_zero != $past(timer_out_zero)) && cnt_q == $past(cc_q[0]) + 16'h0001)
        else $error("compare match on channel zero wrong");
    AST_CAPTURE: assert property (
        (run_q && csel_q[1] && cap_hit[1]) |=> (cc_q[1] == $past(cnt_q)) && chan_match_irq_one)
        else $error("capture on channel one wrong");
    AST_NO_CMP_IN_CAPTURE: assert property (
        (csel_q[0] && !cap_hit[0]) |=> !chan_match_irq_zero)
        else $error("capture channel raised interrupt without edge");
    AST_EVCTL_TRIG: assert property (
        evctl_q[1:0] == 2'b00)
        else $error("trigger select bits not zero");
    AST_COUNT_READ: assert property (
        (req && !wb_we_i && wb_adr_i == frcct_pkg::ADDR_COUNT) |=> wb_dat_o[15:0] == $past(cnt_q))
        else $error("counter read returned wrong value");
    AST_ACK_ONE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    AST_BOTH_CMP: assert property (
        (run_q && !start_w && csel_q == 2'b00 && cc_q[1] == cnt_q) |=> chan_match_irq_one)
        else $error("channel one compare missed");

    COV_MATCH0:   cover property (chan_match_irq_zero);
    COV_CAPTURE1: cover property (run_q && csel_q[1] && cap_hit[1]);
    COV_WRAP:     cover property (overflow_irq);
    COV_IRQ:      cover property (irq);
endmodule

// ### tb/frcct_pin_model.sv
// Model of the pins around the timer: capture sources and output watchers
`timescale 1ns/100ps
module frcct_pin_model
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic timer_out_zero,
    input  wire logic timer_out_one,
    output logic      capture_in_zero,
    output logic      capture_in_one
);
    int   tog0 = 0;
    int   tog1 = 0;
    logic p0   = 1'b0;
    logic p1   = 1'b0;

    initial
    begin
        capture_in_zero = 1'b0;
        capture_in_one  = 1'b0;
    end

    // Counts level changes of the two timer outputs while rst_b is high
    always @(posedge sys_clk)
    begin
        if (rst_b === 1'b1 && timer_out_zero !== p0) tog0++;
        if (rst_b === 1'b1 && timer_out_one !== p1) tog1++;
        p0 = timer_out_zero;
        p1 = timer_out_one;
    end

    // Holds each level long enough to cross the input synchroniser
    task automatic drive(input int ch, input logic lvl);
        @(posedge sys_clk);
        if (ch == 0)
            capture_in_zero <= lvl;
        else
            capture_in_one <= lvl;
        repeat (10) @(posedge sys_clk);
    endtask
endmodule

// ### tb/free_running_capture_compare_timer_tb.sv
// Self-checking bench of the capture/compare timer
`timescale 1ns/100ps
module free_running_capture_compare_timer_tb;
    localparam int DL [2] = '{3000, 5000};
    logic        sys_clk  = 1'b0;
    logic        rst_b    = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        capture_in_zero;
    logic        capture_in_one;
    logic        timer_out_zero;
    logic        timer_out_one;
    logic        chan_match_irq_zero;
    logic        chan_match_irq_one;
    logic        overflow_irq;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] sr;
    logic [15:0] cc [2];
    int          err_count = 0;
    int          compares  = 0;
    int          cyc_n     = 0;
    int          s0        = -1;
    int          n [2]     = '{0, 0};
    int          st [2]    = '{0, 0};
    int          nov       = 0;
    int          stov      = 0;
    int          k;
    int          n0ov;
    bit          ovd;
    int          exp_caps [4] = '{0, 1, 1, 2};

    always #2 sys_clk = ~sys_clk;

    frcct_timer DUT (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .capture_in_zero, .capture_in_one, .timer_out_zero,
        .timer_out_one, .chan_match_irq_zero, .chan_match_irq_one, .overflow_irq, .irq);

    frcct_pin_model pins (.sys_clk, .rst_b, .timer_out_zero, .timer_out_one,
        .capture_in_zero, .capture_in_one);

    // ------------------------------------------------------------
    // Event stamps, counted in clock cycles
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        cyc_n++;
        if (s0 < 0 && timer_out_zero === 1'b1) s0 = cyc_n;
        n[0] += int'(chan_match_irq_zero === 1'b1);
        if (chan_match_irq_zero === 1'b1) st[0] = cyc_n;
        n[1] += int'(chan_match_irq_one === 1'b1);
        if (chan_match_irq_one === 1'b1) st[1] = cyc_n;
        nov += int'(overflow_irq === 1'b1);
        if (overflow_irq === 1'b1) stov = cyc_n;
    end

    // Counter value that the stamp of an event stands for
    function automatic logic [15:0] cnt_at(input int t);
        return 16'(t - s0);
    endfunction

    function automatic logic [15:0] nxt(input logic [15:0] p, input int d);
        logic [16:0] s;
        s = {1'b0, p} + 17'(d);
        if (s > 17'h0_FFFF) s = s - 17'h1_0000;
        return s[15:0];
    endfunction

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && t < 40)
        begin
            @(posedge sys_clk);
            t++;
        end
        rd = wb_dat_o;
        if (t >= 40) err_count++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        test_done;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            rdr(8'(4 * i));
            chk("reset value", 32'h0000_0000, rd);
        end
        wr(frcct_pkg::ADDR_EVCTL, 32'h0000_00FF);
        rdr(frcct_pkg::ADDR_EVCTL);
        chk("event control", 32'h0000_000C, rd);
        wr(8'h24, 32'h0000_00FF);
        rdr(8'h24);
        chk("unmapped", 32'h0000_0000, rd);
        $display("test registers done");

        wr(frcct_pkg::ADDR_CAPSEL, 32'h0000_0000);
        wr(frcct_pkg::ADDR_IRQ_MSK, 32'h0000_0007);
        cc[0] = 16'(DL[0] - 1);
        cc[1] = 16'(DL[1] - 1);
        wr(frcct_pkg::ADDR_CC0, {16'h0000, cc[0]});
        wr(frcct_pkg::ADDR_CC1, {16'h0000, cc[1]});
        wr(frcct_pkg::ADDR_CTRL, 32'h0000_0001);
        rdr(frcct_pkg::ADDR_COUNT);
        sr = rd;
        rdr(frcct_pkg::ADDR_COUNT);
        chk("count step", 32'h0000_0003, rd - sr);
        chk("start toggle 0", 32'h0000_0001, pins.tog0);
        chk("start toggle 1", 32'h0000_0001, pins.tog1);
        $display("test start done");

        ovd = 1'b0;
        n0ov = 0;
        while (!(ovd && n[0] >= n0ov + 2) && err_count == 0)
        begin
            while (irq !== 1'b1) @(posedge sys_clk);
            rdr(frcct_pkg::ADDR_IRQ_ST);
            sr = rd;
            for (int c = 0; c < 2; c++)
            begin
                if (sr[c])
                begin
                    chk("match point", {16'h0000, cc[c] + 16'h0001}, {16'h0000, cnt_at(st[c])});
                    cc[c] = nxt(cc[c], DL[c]);
                    wr(frcct_pkg::ADDR_CC0 + 8'(4 * c), {16'h0000, cc[c]});
                end
            end
            if (sr[2])
            begin
                chk("wrap point", 32'h0000_0000, {16'h0000, cnt_at(stov)});
                rdr(frcct_pkg::ADDR_OPTION);
                chk_bit("overflow flag", 1'b1, rd[0]);
                wr(frcct_pkg::ADDR_OPTION, 32'h0000_0000);
                rdr(frcct_pkg::ADDR_OPTION);
                chk("flag cleared", 32'h0000_0000, rd);
                ovd = 1'b1;
                n0ov = n[0];
            end
            wr(frcct_pkg::ADDR_IRQ_ST, sr);
            repeat (2) @(posedge sys_clk);
        end
        chk("toggles 0", n[0] + 1, pins.tog0);
        chk("toggles 1", n[1] + 1, pins.tog1);
        chk("overflow pulses", 32'h0000_0001, nov);
        $display("test intervals done");

        wr(frcct_pkg::ADDR_OPTION, 32'h0000_0030);
        wr(frcct_pkg::ADDR_IRQ_MSK, 32'h0000_0000);
        wr(frcct_pkg::ADDR_IRQ_ST, 32'h0000_0007);
        wr(frcct_pkg::ADDR_CAPSEL, 32'h0000_0001);
        k = n[0];
        pins.drive(0, 1'b1);
        pins.drive(0, 1'b0);
        chk("captures 0", 32'h0000_0001, n[0] - k);
        rdr(frcct_pkg::ADDR_CC0);
        chk("captured", {16'h0000, cnt_at(st[0]) - 16'h0001}, rd);
        chk_bit("masked irq", 1'b0, irq);
        wr(frcct_pkg::ADDR_IRQ_MSK, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk_bit("unmasked irq", 1'b1, irq);
        wr(frcct_pkg::ADDR_IRQ_ST, 32'h0000_0007);
        repeat (2) @(posedge sys_clk);
        chk_bit("cleared irq", 1'b0, irq);
        for (int c = 0; c < 4; c++)
        begin
            wr(frcct_pkg::ADDR_CAPSEL, {28'h000_0000, 2'(c), 2'b00});
            k = n[1];
            pins.drive(1, 1'b1);
            pins.drive(1, 1'b0);
            chk("edge code captures", exp_caps[c], n[1] - k);
        end
        $display("test capture done");

        wr(frcct_pkg::ADDR_CAPSEL, 32'h0000_0000);
        wr(frcct_pkg::ADDR_OPTION, 32'h0000_0000);
        rdr(frcct_pkg::ADDR_COUNT);
        cc[1] = rd[15:0] + 16'h0064;
        k = n[1];
        wr(frcct_pkg::ADDR_CC1, {16'h0000, cc[1]});
        while (n[1] == k) @(posedge sys_clk);
        chk("new compare", {16'h0000, cc[1] + 16'h0001}, {16'h0000, cnt_at(st[1])});
        $display("test rewrite done");
        test_done;
    end
endmodule
